// ---- core/bridge_ctl_pkg.sv ----
/*
 * Package for the bridge control slice: the configuration dword offset, the
 * control bit positions, reset values, legacy address ranges and the carrier structs.
 * Assumes one PCI clock domain and dword-aligned configuration offsets.
 */
package bridge_ctl_pkg;

    // Configuration dword that holds the interrupt fields and the bridge control bits
    localparam logic [7:0]  INTR_CTRL_OFFSET    = 8'h3c;

    // Interrupt pin field: no interrupt pin
    localparam int          INTR_PIN_LSB        = 8;
    localparam logic [7:0]  INTR_PIN_VALUE      = 8'h00;

    // Bridge control bit positions within the dword
    localparam int          PARITY_RESP_BIT     = 16;
    localparam int          SERR_FWD_BIT        = 17;
    localparam int          ISA_BIT             = 18;
    localparam int          VGA_BIT             = 19;
    localparam int          RSVD_BIT            = 20;
    localparam int          MA_MODE_BIT         = 21;
    localparam int          CTRL_BYTE_LANE      = 2;

    // Reset values of the control bits
    localparam logic        PARITY_RESP_RESET   = 1'b0;
    localparam logic        SERR_FWD_RESET      = 1'b0;
    localparam logic        ISA_RESET           = 1'b0;
    localparam logic        VGA_RESET           = 1'b0;
    localparam logic        RSVD_VALUE          = 1'b0;
    localparam logic        MA_MODE_RESET       = 1'b0;

    // ISA aliasing: first 64KB of I/O space, top 768 bytes of each 1KB block
    localparam logic [15:0] ISA_SPACE_TOP       = 16'hffff;
    localparam logic [1:0]  ISA_LOW_QUARTER     = 2'h0;

    // Legacy VGA ranges; I/O uses ten address bits so aliases match too
    localparam logic [31:0] VGA_MEM_LO          = 32'h000a_0000;
    localparam logic [31:0] VGA_MEM_HI          = 32'h000b_ffff;
    localparam logic [9:0]  VGA_IO_A_LO         = 10'h3b0;
    localparam logic [9:0]  VGA_IO_A_HI         = 10'h3bb;
    localparam logic [9:0]  VGA_IO_B_LO         = 10'h3c0;
    localparam logic [9:0]  VGA_IO_B_HI         = 10'h3df;

    // Data returned for a hidden master-aborted read
    localparam logic [31:0] MA_READ_DATA        = 32'hffff_ffff;

    // Configuration access from the primary target logic
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    // Address decode request: one address per cycle
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        from_secondary;
        logic [31:0] addr;
        logic [31:0] io_base;
        logic [31:0] io_limit;
    } decode_req_t;

    // Master abort seen on the secondary interface
    typedef struct packed {
        logic        valid;
        logic        is_read;
        logic        target_abort_ok;
    } abort_evt_t;

    // Decode answer
    typedef struct packed {
        logic        valid;
        logic        forward_down;
        logic        forward_up;
        logic        vga_claim;
    } decode_rsp_t;

    // Master abort answer
    typedef struct packed {
        logic        complete_quiet;
        logic        target_abort;
        logic [31:0] rdata;
    } abort_rsp_t;

endpackage

// ---- core/bridge_control_forwarding_bits.sv ----
/*
 * Interrupt pin field and bridge control bits 16..21 of a PCI-to-PCI bridge,
 * with the address, parity, system-error and master-abort logic they steer.
 * Assumes configuration, decode and abort requests come from logic on clock_i;
 * the secondary system-error pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps

// Functional notes
// - Interrupt pin field is read-only, shows no interrupt pin provided.
// - Parity response bit 0 (reset): secondary address/data parity errors ignored.
// - Parity response bit 1: secondary parity errors detected and reported.
// - Secondary system error reaches primary only while forwarding bit set; resets 0.
// - ISA bit 0 (reset): forward every I/O address inside base-limit window.
// - ISA bit 1: block window addresses below 64KB in top 768 bytes per 1KB.
// - ISA bit 1: forward secondary I/O upstream when in top 768 bytes per 1KB.
// - VGA bit 0 (reset): legacy VGA memory not passed downstream; VGA I/O passed only inside the base-limit window.
// - VGA bit 1: forward VGA memory and I/O downstream, overriding other settings.
// - Bit 20 reads zero, ignores writes, resets to zero.
// - Master-abort mode 0 (reset): hide aborts, reads return all ones, writes dropped.
// - Master-abort mode 1: signal target abort if possible, else system error if enabled.
module bridge_control_forwarding_bits (
    input  wire logic                         clock_i,
    input  wire logic                         rst_n_i,
    input  wire bridge_ctl_pkg::cfg_req_t     cfg_req_i,
    output logic [31:0]                       cfg_rdata_o,
    output logic                              cfg_rvalid_o,
    input  wire bridge_ctl_pkg::decode_req_t  decode_req_i,
    output bridge_ctl_pkg::decode_rsp_t       decode_rsp_o,
    input  wire logic                         sec_parity_error_i,
    output logic                              sec_parity_report_o,
    input  wire logic                         secondary_system_error_n_i,
    input  wire logic                         serr_enable_i,
    output logic                              primary_system_error_n_o,
    output logic                              primary_system_error_oe_o,
    input  wire bridge_ctl_pkg::abort_evt_t   abort_evt_i,
    output bridge_ctl_pkg::abort_rsp_t        abort_rsp_o,
    output logic                              parity_resp_o,
    output logic                              isa_mode_o,
    output logic                              vga_mode_o,
    output logic                              ma_mode_o
);

    typedef struct packed {
        logic                        serr_sync1;
        logic                        serr_sync2;
        logic                        parity_resp;
        logic                        serr_fwd;
        logic                        isa;
        logic                        vga;
        logic                        ma_mode;
        logic [31:0]                 rdata;
        logic                        rvalid;
        bridge_ctl_pkg::decode_rsp_t dec;
        logic                        parity_report;
        logic                        serr_drive;
        logic                        serr_n;
        bridge_ctl_pkg::abort_rsp_t  abort;
    } state_t;

    state_t state;
    state_t next_state;

    // Top 768 bytes of a 1KB block: offset bits 9:8 not in the low quarter
    function automatic logic isa_alias(input logic [31:0] addr);
        return addr[9:8] != bridge_ctl_pkg::ISA_LOW_QUARTER;
    endfunction

    // Legacy VGA decode; I/O compares ten bits only so every alias matches
    function automatic logic vga_match(input logic is_io, input logic [31:0] addr);
        logic io_hit;
        logic mem_hit;
        io_hit  = (addr[9:0] >= bridge_ctl_pkg::VGA_IO_A_LO && addr[9:0] <= bridge_ctl_pkg::VGA_IO_A_HI) ||
                  (addr[9:0] >= bridge_ctl_pkg::VGA_IO_B_LO && addr[9:0] <= bridge_ctl_pkg::VGA_IO_B_HI);
        mem_hit = addr >= bridge_ctl_pkg::VGA_MEM_LO && addr <= bridge_ctl_pkg::VGA_MEM_HI;
        return is_io ? io_hit : mem_hit;
    endfunction

    // Read image of the shared dword; interrupt line lives elsewhere and reads zero here
    function automatic logic [31:0] dword_image(input state_t s);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[bridge_ctl_pkg::INTR_PIN_LSB +: 8] = bridge_ctl_pkg::INTR_PIN_VALUE;
        img[bridge_ctl_pkg::PARITY_RESP_BIT]   = s.parity_resp;
        img[bridge_ctl_pkg::SERR_FWD_BIT]      = s.serr_fwd;
        img[bridge_ctl_pkg::ISA_BIT]           = s.isa;
        img[bridge_ctl_pkg::VGA_BIT]           = s.vga;
        img[bridge_ctl_pkg::RSVD_BIT]          = bridge_ctl_pkg::RSVD_VALUE;
        img[bridge_ctl_pkg::MA_MODE_BIT]       = s.ma_mode;
        return img;
    endfunction

    logic        in_window;
    logic        below_64k;
    logic        vga_hit;
    logic        ma_serr;
    logic        cfg_hit;

    // Next-state logic for the whole slice
    always_comb begin
        next_state = state;

        // Pin crosses two flops before anything reads it
        next_state.serr_sync1 = secondary_system_error_n_i;
        next_state.serr_sync2 = state.serr_sync1;

        // Configuration write; only byte lane 2 carries writable bits
        cfg_hit = cfg_req_i.offset == bridge_ctl_pkg::INTR_CTRL_OFFSET;
        if (cfg_req_i.write && cfg_hit && cfg_req_i.byte_en[bridge_ctl_pkg::CTRL_BYTE_LANE]) begin
            next_state.parity_resp = cfg_req_i.wdata[bridge_ctl_pkg::PARITY_RESP_BIT];
            next_state.serr_fwd    = cfg_req_i.wdata[bridge_ctl_pkg::SERR_FWD_BIT];
            next_state.isa         = cfg_req_i.wdata[bridge_ctl_pkg::ISA_BIT];
            next_state.vga         = cfg_req_i.wdata[bridge_ctl_pkg::VGA_BIT];
            next_state.ma_mode     = cfg_req_i.wdata[bridge_ctl_pkg::MA_MODE_BIT];
        end

        // Read answers one cycle later; other offsets read zero from this slice
        next_state.rvalid = cfg_req_i.read;
        next_state.rdata  = (cfg_req_i.read && cfg_hit) ? dword_image(state) : 32'h0000_0000;

        // Address decode, answered one cycle after the request
        in_window = decode_req_i.addr >= decode_req_i.io_base && decode_req_i.addr <= decode_req_i.io_limit;
        below_64k = decode_req_i.addr[31:16] == 16'h0000 && decode_req_i.addr[15:0] <= bridge_ctl_pkg::ISA_SPACE_TOP;
        vga_hit   = vga_match(decode_req_i.is_io, decode_req_i.addr);
        next_state.dec.valid        = decode_req_i.valid;
        next_state.dec.forward_down = 1'b0;
        next_state.dec.forward_up   = 1'b0;
        next_state.dec.vga_claim    = 1'b0;
        if (decode_req_i.valid && !decode_req_i.from_secondary) begin
            if (state.vga && vga_hit) begin
                // VGA wins over window and enable settings
                next_state.dec.forward_down = 1'b1;
                next_state.dec.vga_claim    = 1'b1;
            end else if (decode_req_i.is_io && in_window) begin
                // ISA aliases in the first 64KB stay on the primary side
                next_state.dec.forward_down = !(state.isa && below_64k && isa_alias(decode_req_i.addr));
            end
            // VGA addresses otherwise get no vga_claim here; VGA I/O inside the window forwards down unless the ISA bit blocks it below 64KB
        end
        if (decode_req_i.valid && decode_req_i.from_secondary && decode_req_i.is_io) begin
            next_state.dec.forward_up = state.isa && isa_alias(decode_req_i.addr);
        end

        // Secondary parity errors reported only when response is enabled
        next_state.parity_report = sec_parity_error_i && state.parity_resp;

        // Master abort handling; mode 0 completes quietly
        next_state.abort.complete_quiet = 1'b0;
        next_state.abort.target_abort   = 1'b0;
        next_state.abort.rdata          = 32'h0000_0000;
        ma_serr = 1'b0;
        if (abort_evt_i.valid) begin
            if (!state.ma_mode) begin
                next_state.abort.complete_quiet = 1'b1;
                next_state.abort.rdata = abort_evt_i.is_read ? bridge_ctl_pkg::MA_READ_DATA : 32'h0000_0000;
            end else if (abort_evt_i.target_abort_ok) begin
                next_state.abort.target_abort = 1'b1;
            end else begin
                ma_serr = serr_enable_i;
            end
        end

        // Primary system error: forwarded secondary level, or a one-cycle abort report
        next_state.serr_drive = (state.serr_fwd && !state.serr_sync2) || ma_serr;
        // Pin level kept in its own flop so the output has no gate after the register
        next_state.serr_n     = !next_state.serr_drive;
    end

    // State register; every field resets to a constant
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state             <= '0;
            state.serr_sync1  <= 1'b1;
            state.serr_sync2  <= 1'b1;
            state.serr_n      <= 1'b1;
            state.parity_resp <= bridge_ctl_pkg::PARITY_RESP_RESET;
            state.serr_fwd    <= bridge_ctl_pkg::SERR_FWD_RESET;
            state.isa         <= bridge_ctl_pkg::ISA_RESET;
            state.vga         <= bridge_ctl_pkg::VGA_RESET;
            state.ma_mode     <= bridge_ctl_pkg::MA_MODE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops; the pin is open drain, driven low only
    assign cfg_rdata_o               = state.rdata;
    assign cfg_rvalid_o              = state.rvalid;
    assign decode_rsp_o              = state.dec;
    assign sec_parity_report_o       = state.parity_report;
    assign primary_system_error_n_o  = state.serr_n;
    assign primary_system_error_oe_o = state.serr_drive;
    assign abort_rsp_o               = state.abort;
    assign parity_resp_o             = state.parity_resp;
    assign isa_mode_o                = state.isa;
    assign vga_mode_o                = state.vga;
    assign ma_mode_o                 = state.ma_mode;

endmodule

// ---- tb/bridge_ctl_props.sv ----
/* Checker for the bridge control slice: read, decode, parity and abort timing.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/1ps
module bridge_ctl_props (
    input wire logic                        clock_i,
    input wire logic                        rst_n_i,
    input wire bridge_ctl_pkg::cfg_req_t    cfg_req_i,
    input wire logic [31:0]                 cfg_rdata_o,
    input wire logic                        cfg_rvalid_o,
    input wire bridge_ctl_pkg::decode_req_t decode_req_i,
    input wire bridge_ctl_pkg::decode_rsp_t decode_rsp_o,
    input wire logic                        sec_parity_error_i,
    input wire logic                        sec_parity_report_o,
    input wire logic                        serr_enable_i,
    input wire logic                        primary_system_error_oe_o,
    input wire bridge_ctl_pkg::abort_evt_t  abort_evt_i,
    input wire bridge_ctl_pkg::abort_rsp_t  abort_rsp_o,
    input wire logic                        parity_resp_o,
    input wire logic                        isa_mode_o,
    input wire logic                        vga_mode_o,
    input wire logic                        ma_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Request qualifiers, kept apart so the properties stay readable
    logic prim;
    logic vga_mem;
    logic in_win;
    assign prim    = decode_req_i.valid && !decode_req_i.from_secondary;
    assign vga_mem = decode_req_i.addr >= 32'h000a_0000 && decode_req_i.addr <= 32'h000b_ffff;
    assign in_win  = decode_req_i.addr >= decode_req_i.io_base && decode_req_i.addr <= decode_req_i.io_limit;
    chk_rd_answer: assert property (
        cfg_req_i.read |=> cfg_rvalid_o && cfg_rdata_o[15:8] == 8'h00) else $error("read answer wrong");
    chk_rsvd_zero: assert property (
        cfg_rvalid_o |-> !cfg_rdata_o[20]) else $error("reserved bit set");
    chk_par_quiet: assert property (
        sec_parity_error_i && !parity_resp_o |=> !sec_parity_report_o) else $error("parity reported");
    chk_par_report: assert property (
        sec_parity_error_i && parity_resp_o |=> sec_parity_report_o) else $error("parity not reported");
    chk_isa_window: assert property (
        prim && decode_req_i.is_io && in_win && !isa_mode_o && !vga_mode_o |=> decode_rsp_o.forward_down)
        else $error("window io not forwarded");
    chk_isa_block: assert property (
        prim && decode_req_i.is_io && in_win && isa_mode_o && !vga_mode_o && decode_req_i.addr < 32'h0001_0000
        && decode_req_i.addr[9:8] != 2'h0 |=> !decode_rsp_o.forward_down) else $error("isa alias forwarded");
    chk_isa_up: assert property (
        decode_req_i.valid && decode_req_i.from_secondary && decode_req_i.is_io && isa_mode_o
        && decode_req_i.addr[9:8] != 2'h0 |=> decode_rsp_o.forward_up) else $error("isa alias not sent up");
    chk_vga_off: assert property (
        decode_req_i.valid && !vga_mode_o |=> !decode_rsp_o.vga_claim) else $error("vga claimed");
    chk_vga_mem: assert property (
        prim && !decode_req_i.is_io && vga_mem && vga_mode_o |=> decode_rsp_o.forward_down && decode_rsp_o.vga_claim)
        else $error("vga memory not forwarded");
    chk_ma_quiet: assert property (
        abort_evt_i.valid && !ma_mode_o |=> abort_rsp_o.complete_quiet && !abort_rsp_o.target_abort
        && abort_rsp_o.rdata == ($past(abort_evt_i.is_read) ? 32'hffff_ffff : 32'h0000_0000))
        else $error("quiet abort wrong");
    chk_ma_target: assert property (
        abort_evt_i.valid && ma_mode_o && abort_evt_i.target_abort_ok |=> abort_rsp_o.target_abort)
        else $error("target abort missing");
    chk_ma_serr: assert property (
        abort_evt_i.valid && ma_mode_o && !abort_evt_i.target_abort_ok && serr_enable_i
        |=> primary_system_error_oe_o) else $error("abort system error missing");
endmodule
bind bridge_control_forwarding_bits bridge_ctl_props i_props (.clock_i, .rst_n_i, .cfg_req_i, .cfg_rdata_o,
    .cfg_rvalid_o, .decode_req_i, .decode_rsp_o, .sec_parity_error_i, .sec_parity_report_o, .serr_enable_i,
    .primary_system_error_oe_o, .abort_evt_i, .abort_rsp_o, .parity_resp_o, .isa_mode_o, .vga_mode_o, .ma_mode_o);

// ---- tb/sec_agent.sv ----
/* Secondary bus agent: system error line driven low or high, and parity error pulses.
   Assumes requests from the bench on clock_i. */
`timescale 1ns/1ps
module sec_agent (
    input  wire logic clock_i,
    input  wire logic serr_req_i,
    input  wire logic par_req_i,
    output logic      serr_n_o,
    output logic      par_err_o
);
    // Released line is driven high, standing in for the pull-up level
    assign serr_n_o = serr_req_i ? 1'b0 : 1'b1;
    // A bad transfer is flagged one cycle later
    always_ff @(posedge clock_i) par_err_o <= par_req_i;
endmodule

// ---- tb/tb.sv ----
/* Self-checking bench for the bridge control slice with three scoreboard queues.
   Assumes the package, the design, the agent and the checker are compiled first. */
`timescale 1ns/1ps
module tb;
    logic                        clock_i, rst_n_i, serr_req, par_req, serr_enable_i;
    logic                        secondary_system_error_n_i, sec_parity_error_i, sec_parity_report_o;
    logic                        cfg_rvalid_o, primary_system_error_n_o, primary_system_error_oe_o;
    logic [31:0]                 cfg_rdata_o, ctl, rd_q[$];
    bridge_ctl_pkg::cfg_req_t    cfg_req_i;
    bridge_ctl_pkg::decode_req_t decode_req_i, dr;
    bridge_ctl_pkg::decode_rsp_t decode_rsp_o, dec_q[$];
    bridge_ctl_pkg::abort_evt_t  abort_evt_i;
    bridge_ctl_pkg::abort_rsp_t  abort_rsp_o, ab_q[$];
    int                          err_total = 0, checked = 0, seed = 32'h3305;
    bridge_control_forwarding_bits i_dut (.clock_i, .rst_n_i, .cfg_req_i, .cfg_rdata_o, .cfg_rvalid_o,
        .decode_req_i, .decode_rsp_o, .sec_parity_error_i, .sec_parity_report_o, .secondary_system_error_n_i,
        .serr_enable_i, .primary_system_error_n_o, .primary_system_error_oe_o, .abort_evt_i, .abort_rsp_o,
        .parity_resp_o(), .isa_mode_o(), .vga_mode_o(), .ma_mode_o());
    sec_agent i_agent (.clock_i, .serr_req_i(serr_req), .par_req_i(par_req),
        .serr_n_o(secondary_system_error_n_i), .par_err_o(sec_parity_error_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task tally(input bit ok, input string m);
        checked++;
        if (!ok) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task cmp_rd(input logic [31:0] g, e); tally(g === e, "read data"); endtask
    task cmp_dec(input bridge_ctl_pkg::decode_rsp_t g, e); tally(g === e, "decode answer"); endtask
    task cmp_pin(input logic g, e); tally(g === e, "system error pin"); endtask
    task cmp_par(input logic g, e); tally(g === e, "parity report"); endtask
    task cmp_ab(input bridge_ctl_pkg::abort_rsp_t g, e); tally(g === e, "abort answer"); endtask
    // Expected decode answer; masked writes keep ctl equal to the live bits
    function automatic bridge_ctl_pkg::decode_rsp_t expd(input bridge_ctl_pkg::decode_req_t r);
        logic [9:0] a;
        logic       hit;
        a = r.addr[9:0];
        hit = r.is_io ? (a >= 10'h3b0 && a <= 10'h3bb) || (a >= 10'h3c0 && a <= 10'h3df)
                      : r.addr >= 32'h000a_0000 && r.addr <= 32'h000b_ffff;
        expd = '0;
        expd.valid = 1'b1;
        if (r.from_secondary) expd.forward_up = r.is_io && ctl[18] && a[9:8] != 2'h0;
        else if (ctl[19] && hit) {expd.forward_down, expd.vga_claim} = 2'h3;
        else if (r.is_io && r.addr >= r.io_base && r.addr <= r.io_limit)
            expd.forward_down = !(ctl[18] && r.addr < 32'h0001_0000 && a[9:8] != 2'h0);
    endfunction
    task cfg(input logic r, w, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock_i);
        cfg_req_i <= {r, w, off, be, d};
        if (w && off == 8'h3c && be[2]) ctl = d & 32'h002f_0000;
        if (r) rd_q.push_back(off == 8'h3c ? ctl : 32'h0000_0000);
        @(posedge clock_i);
        cfg_req_i <= '0;
    endtask
    task dec(input bridge_ctl_pkg::decode_req_t r);
        @(posedge clock_i);
        decode_req_i <= r;
        dec_q.push_back(expd(r));
        @(posedge clock_i);
        decode_req_i <= '0;
    endtask
    task abort(input logic rd, ok);
        @(posedge clock_i);
        abort_evt_i <= {1'b1, rd, ok};
        if (!ctl[21]) ab_q.push_back({1'b1, 1'b0, rd ? 32'hffff_ffff : 32'h0000_0000});
        else if (ok) ab_q.push_back({1'b0, 1'b1, 32'h0000_0000});
        @(posedge clock_i);
        abort_evt_i <= '0;
    endtask
    // Scoreboard: every answer takes the oldest note
    // Sampled on the falling edge, where registered answers have settled
    always @(negedge clock_i) begin
        if (cfg_rvalid_o === 1'b1) cmp_rd(cfg_rdata_o, rd_q.pop_front());
        if (decode_rsp_o.valid === 1'b1) cmp_dec(decode_rsp_o, dec_q.pop_front());
        if (abort_rsp_o.complete_quiet === 1'b1 || abort_rsp_o.target_abort === 1'b1)
            cmp_ab(abort_rsp_o, ab_q.pop_front());
    end
    // Watchdog sized far above the expected few hundred cycles
    initial begin
        #100000;
        err_total++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        {cfg_req_i, decode_req_i, abort_evt_i, serr_req, par_req, rst_n_i} = '0;
        serr_enable_i = 1'b1;
        ctl = '0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        cfg(1'b1, 1'b0, 8'h3c, 4'h0, '0);
        cfg(1'b0, 1'b1, 8'h3c, 4'hb, 32'hffff_ffff);
        cfg(1'b0, 1'b1, 8'h40, 4'hf, 32'hffff_ffff);
        cfg(1'b1, 1'b0, 8'h40, 4'hf, '0);
        repeat (12) begin
            cfg(1'b0, 1'b1, 8'h3c, 4'($random(seed)), 32'($random(seed)));
            cfg(1'b1, 1'b0, 8'h3c, 4'hf, '0);
        end
        $display("test config done");
        for (int m = 0; m < 4; m++) begin
            cfg(1'b0, 1'b1, 8'h3c, 4'h4, 32'(m) << 18);
            repeat (24) begin
                dr.valid = 1'b1;
                dr.is_io = 1'($random(seed));
                dr.from_secondary = 2'($random(seed)) == 2'h0;
                dr.addr = dr.is_io ? 32'($random(seed)) & 32'h0001_ffff
                                   : 32'($random(seed)) & 32'h0003_ffff | 32'h0009_0000;
                if (2'($random(seed)) == 2'h0) dr.addr[9:0] = 10'h3b0 + (10'($random(seed)) & 10'h02f);
                dr.io_base = 32'($random(seed)) & 32'h0000_ffff;
                dr.io_limit = dr.io_base + (32'($random(seed)) & 32'h0001_ffff);
                dec(dr);
            end
        end
        $display("test decode done");
        for (int p = 0; p < 2; p++) begin
            cfg(1'b0, 1'b1, 8'h3c, 4'h4, 32'(p) << 16);
            @(posedge clock_i) par_req <= 1'b1;
            @(posedge clock_i) par_req <= 1'b0;
            @(posedge clock_i);
            @(negedge clock_i);
            cmp_par(sec_parity_report_o, 1'(p));
            repeat (2) @(posedge clock_i);
        end
        $display("test parity done");
        for (int f = 1; f >= 0; f--) begin
            cfg(1'b0, 1'b1, 8'h3c, 4'h4, 32'(f) << 17);
            @(posedge clock_i) serr_req <= 1'b1;
            repeat (4) @(posedge clock_i);
            @(negedge clock_i);
            cmp_pin(primary_system_error_oe_o, 1'(f));
            cmp_pin(primary_system_error_n_o, !1'(f));
            @(posedge clock_i) serr_req <= 1'b0;
            repeat (4) @(posedge clock_i);
            @(negedge clock_i);
            cmp_pin(primary_system_error_oe_o, 1'b0);
            cmp_pin(primary_system_error_n_o, 1'b1);
        end
        $display("test system error done");
        for (int mo = 0; mo < 2; mo++) begin
            cfg(1'b0, 1'b1, 8'h3c, 4'h4, 32'(mo) << 21);
            for (int k = 0; k < 4; k++) begin
                serr_enable_i <= 1'($random(seed));
                abort(k[0], k[1]);
                @(negedge clock_i);
                cmp_pin(primary_system_error_oe_o, ctl[21] && !k[1] && serr_enable_i);
                repeat (2) @(posedge clock_i);
            end
        end
        $display("test abort done");
        // Mid-run reset must bring every control bit back to zero
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        ctl = '0;
        cfg(1'b1, 1'b0, 8'h3c, 4'hf, '0);
        $display("test reset done");
        repeat (3) @(posedge clock_i);
        tally(rd_q.size() == 0 && dec_q.size() == 0 && ab_q.size() == 0, "answers missing");
        summarize();
    end
endmodule
